// File: verilog/touch_i2c_slave.sv
// serial slave front end of the touch converter: command decode,
// acquisition and conversion sequencing, result read-back
// assumes core clock far faster than the serial clock; converter outside
`timescale 1ns/1ps
module touch_i2c_slave (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  touch_i2c_if.slave       bus,
  input  wire logic [1:0]  device_select_pins_i,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] result_i,
  output logic [3:0]       config_select_field_o,
  output logic             mux_en_o,
  output logic             x_drive_o,
  output logic             y_drive_o,
  output logic             diff_ref_o,
  output logic             acquire_o,
  output logic             conv_start_o,
  output logic             conv_busy_o,
  output logic             mode_8bit_o,
  output logic [1:0]       power_down_field_o,
  output logic             reference_power_bit_o,
  output logic             pen_touch_interrupt_en_o,
  output logic             hs_mode_o
);

  // ***********************************************************
  // types and functions
  // ***********************************************************
  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_ADDR     = 4'h1,
    S_ADDR_ACK = 4'h2,
    S_CMD      = 4'h3,
    S_CMD_ACK  = 4'h4,
    S_STRETCH  = 4'h5,
    S_TX       = 4'h6,
    S_TX_ACK   = 4'h7,
    S_WAIT     = 4'h8
  } state_e;

  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [1:0] sel);
    addr_match = (a[7:3] == touch_i2c_pkg::PRESET_CODE)
              && (a[2:1] == sel);
  endfunction

  // {x drivers, y drivers} for a config code
  function automatic logic [1:0] drivers(input logic [3:0] c);
    drivers = 2'b00;
    if (c[3]) begin
      case (c[2:0])
        3'h0, 3'h4: drivers = 2'b10;
        3'h1, 3'h5: drivers = 2'b01;
        3'h2, 3'h6, 3'h7: drivers = 2'b11;
        default: drivers = 2'b00;
      endcase
    end
  endfunction

  // channel routed to the converter input
  function automatic logic ch_valid(input logic [3:0] c);
    ch_valid = (c[1:0] != 2'b11) && (!c[3] || c[2]);
  endfunction

  // ***********************************************************
  // synchronisers and bus conditions
  // ***********************************************************
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_d;
  logic       sda_d;
  logic [1:0] sel_s0;
  logic [1:0] sel_s1;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s  <= 2'h3;
      sda_s  <= 2'h3;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      sel_s0 <= 2'h0;
      sel_s1 <= 2'h0;
    end else begin
      scl_s  <= {scl_s[0], bus.scl};
      sda_s  <= {sda_s[0], bus.sda};
      scl_d  <= scl_s[1];
      sda_d  <= sda_s[1];
      sel_s0 <= device_select_pins_i;
      sel_s1 <= sel_s0;
    end
  end

  logic scl_h;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_h     = scl_s[1];
  assign sda_h     = sda_s[1];
  assign scl_rise  = scl_h & ~scl_d;
  assign scl_fall  = ~scl_h & scl_d;
  assign start_det = scl_h & scl_d & sda_d & ~sda_h;
  assign stop_det  = scl_h & scl_d & ~sda_d & sda_h;

  // ***********************************************************
  // byte engine
  // ***********************************************************
  state_e     state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic       rw_q;
  logic       byte_hi_q;
  logic       sda_oe_q;
  logic       scl_oe_q;
  logic       conv_busy_q;
  logic [11:0] result_q;
  logic [7:0] next_byte;

  assign next_byte = byte_hi_q ? result_q[11:4]
                               : {result_q[3:0], 4'h0};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= S_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      byte_hi_q <= 1'b1;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
    end else if (start_det) begin
      state_q   <= S_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= S_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_CMD: begin
          if (scl_rise) begin
            sh_q      <= {sh_q[6:0], sda_h};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            if (state_q == S_CMD) begin
              sda_oe_q <= 1'b1;
              state_q  <= S_CMD_ACK;
            end else if (addr_match(sh_q, sel_s1)) begin
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
              state_q  <= S_ADDR_ACK;
            end else begin
              state_q <= S_WAIT;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              scl_oe_q <= 1'b1;
              state_q  <= S_STRETCH;
            end else begin
              state_q <= S_CMD;
            end
          end
        end
        S_CMD_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            state_q  <= S_WAIT;
          end
        end
        S_STRETCH: begin
          if (!conv_busy_q) begin
            sh_q      <= result_q[11:4];
            sda_oe_q  <= ~result_q[11];
            byte_hi_q <= 1'b0;
            state_q   <= S_TX;
          end
        end
        S_TX: begin
          // clock let go one cycle after the first data bit is set up
          scl_oe_q <= 1'b0;
          if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              sda_oe_q  <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= S_TX_ACK;
            end else begin
              sh_q      <= {sh_q[6:0], 1'b0};
              sda_oe_q  <= ~sh_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise && sda_h) begin
            state_q <= S_WAIT;
          end else if (scl_fall) begin
            sh_q      <= next_byte;
            sda_oe_q  <= ~next_byte[7];
            byte_hi_q <= ~byte_hi_q;
            state_q   <= S_TX;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign bus.sda_s_oe = sda_oe_q;
  assign bus.scl_s_oe = scl_oe_q;

  // ***********************************************************
  // command, acquisition and conversion
  // ***********************************************************
  logic [7:0] cmd_q;
  logic       cmd_done_q;
  logic [3:0] cfg_in;
  logic       wr_addr_ack;
  logic       hs_code;

  assign cfg_in      = {sh_q[2:0], sda_h};
  assign wr_addr_ack = (state_q == S_ADDR) && scl_fall
                    && (bit_cnt_q == 4'h8) && addr_match(sh_q, sel_s1)
                    && !sh_q[0];
  assign hs_code     = (state_q == S_ADDR) && scl_fall
                    && (bit_cnt_q == 4'h8)
                    && (sh_q[7:3] == touch_i2c_pkg::HS_CODE);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q                 <= touch_i2c_pkg::CMD_RESET;
      cmd_done_q            <= 1'b0;
      config_select_field_o <= 4'h0;
      mux_en_o              <= 1'b0;
      x_drive_o             <= 1'b0;
      y_drive_o             <= 1'b0;
      diff_ref_o            <= 1'b0;
      acquire_o             <= 1'b0;
      conv_start_o          <= 1'b0;
      conv_busy_q           <= 1'b0;
      result_q              <= touch_i2c_pkg::RESULT_RESET;
      mode_8bit_o           <= 1'b0;
      power_down_field_o    <= 2'h0;
      reference_power_bit_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      if (state_q == S_CMD && scl_rise && bit_cnt_q == 4'h3) begin
        config_select_field_o <= cfg_in;
        mux_en_o              <= ch_valid(cfg_in);
        diff_ref_o            <= cfg_in[3];
      end
      if (state_q == S_CMD && scl_fall && bit_cnt_q == 4'h4) begin
        acquire_o <= 1'b1;
        {x_drive_o, y_drive_o} <= drivers(config_select_field_o);
      end
      if (state_q == S_CMD && scl_fall && bit_cnt_q == 4'h8) begin
        cmd_q      <= sh_q;
        cmd_done_q <= 1'b1;
      end
      if ((start_det || stop_det) && cmd_done_q) begin
        reference_power_bit_o <= cmd_q[touch_i2c_pkg::PD1_POS];
        power_down_field_o    <= cmd_q[touch_i2c_pkg::PD0_POS +: 2];
        mode_8bit_o  <= cmd_q[touch_i2c_pkg::MODE_POS];
        acquire_o    <= 1'b0;
        mux_en_o     <= 1'b0;
        conv_start_o <= 1'b1;
        conv_busy_q  <= 1'b1;
        cmd_done_q   <= 1'b0;
      end else if (start_det || stop_det) begin
        acquire_o <= 1'b0;
      end else if (conv_done_i && conv_busy_q) begin
        result_q    <= result_i;
        conv_busy_q <= 1'b0;
        if (!cmd_q[touch_i2c_pkg::PD0_POS]) begin
          x_drive_o <= 1'b0;
          y_drive_o <= 1'b0;
        end
      end
    end
  end

  assign conv_busy_o = conv_busy_q;

  // ***********************************************************
  // pen interrupt enable and high-speed mode
  // ***********************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pen_touch_interrupt_en_o <= 1'b1;
      hs_mode_o                <= 1'b0;
    end else begin
      if (wr_addr_ack) begin
        pen_touch_interrupt_en_o <= 1'b0;
      end else if (conv_done_i && conv_busy_q) begin
        pen_touch_interrupt_en_o <= ~cmd_q[touch_i2c_pkg::PD0_POS]
                                  & ~(|drivers(cmd_q[7:4]) & ~cmd_q[6]);
      end
      if (stop_det) begin
        hs_mode_o <= 1'b0;
      end else if (hs_code) begin
        hs_mode_o <= 1'b1;
      end
    end
  end

endmodule

// File: include/touch_i2c_pkg.sv
// constants shared by the touch converter serial slave and its master
// assumes a single core clock of 250 MHz on both ends
package touch_i2c_pkg;
  // device-type code: value is arbitrary
  localparam logic [4:0] PRESET_CODE = 5'h0B;
  localparam logic [4:0] HS_CODE     = 5'h01;
  // command byte field positions
  localparam int CFG_LSB  = 4;
  localparam int PD1_POS  = 3;
  localparam int PD0_POS  = 2;
  localparam int MODE_POS = 1;
  // reset values
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // master register offsets
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_CMD    = 3'h1;
  localparam logic [2:0] REG_DSEL   = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RESULT = 3'h4;
  // control bits
  localparam int CTRL_WRITE = 0;
  localparam int CTRL_READ  = 1;
  localparam int CTRL_TWO   = 2;
  localparam int CTRL_HS    = 3;
  // serial clock timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYCLES    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

// File: include/touch_i2c_if.sv
// open-drain two-wire link between master and converter slave
// assumes pull-ups: a line is low while any end enables its driver
`timescale 1ns/1ps
interface touch_i2c_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic scl_s_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_m_oe | scl_s_oe);
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave  (output scl_s_oe, output sda_s_oe, input scl, input sda);
endinterface

// File: verilog/touch_i2c_master.sv
// serial bus master for the touch converter: writes a command,
// reads back the result; software drives it through a small port
// assumes a 250 MHz core clock; serial clock made by a divider
`timescale 1ns/1ps
module touch_i2c_master (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  touch_i2c_if.master      bus,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o
);

  // ***********************************************************
  // state and synchronisers
  // ***********************************************************
  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_BYTE  = 2'h2,
    M_STOP  = 2'h3
  } mstate_e;

  localparam int QW = $clog2(touch_i2c_pkg::QTR_CYCLES + 1);

  mstate_e     st_q;
  logic [1:0]  scl_s;
  logic [1:0]  sda_s;
  logic [QW-1:0] qcnt_q;
  logic        tick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [1:0]  seq_q;
  logic [7:0]  tx_q;
  logic [15:0] rx_q;
  logic [15:0] result_q;
  logic [7:0]  cmd_q;
  logic [1:0]  dsel_q;
  logic        rd_q;
  logic        two_q;
  logic        hs_q;
  logic        busy_q;
  logic        nack_q;
  logic        ackin_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic        is_rx;
  logic        last;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
    end else begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qcnt_q <= '0;
    end else if (tick || st_q == M_IDLE) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + QW'(1);
    end
  end

  assign tick  = (qcnt_q == QW'(touch_i2c_pkg::QTR_CYCLES - 1));
  assign is_rx = rd_q && (seq_q != 2'h0);
  // two on a write sends the command byte a second time
  assign last  = (seq_q == (two_q ? 2'h2 : 2'h1));

  // ***********************************************************
  // bit sequencer
  // ***********************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      seq_q <= 2'h0;
      tx_q <= 8'h00;
      rx_q <= 16'h0000;
      result_q <= 16'h0000;
      rd_q <= 1'b0;
      two_q <= 1'b0;
      hs_q <= 1'b0;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      ackin_q <= 1'b1;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (st_q == M_IDLE) begin
      if (wr_i && addr_i == touch_i2c_pkg::REG_CTRL
          && (wdata_i[touch_i2c_pkg::CTRL_WRITE]
              || wdata_i[touch_i2c_pkg::CTRL_READ])) begin
        rd_q   <= wdata_i[touch_i2c_pkg::CTRL_READ];
        two_q  <= wdata_i[touch_i2c_pkg::CTRL_TWO];
        hs_q   <= wdata_i[touch_i2c_pkg::CTRL_HS];
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        ph_q   <= 2'h0;
        st_q   <= M_START;
      end
    end else if (tick) begin
      ph_q <= ph_q + 2'h1;
      case (st_q)
        M_START: begin
          if (ph_q == 2'h0) sda_oe_q <= 1'b0;
          if (ph_q == 2'h1) scl_oe_q <= 1'b0;
          if (ph_q == 2'h2) begin
            if (scl_s[1]) sda_oe_q <= 1'b1;
            else ph_q <= ph_q;
          end
          if (ph_q == 2'h3) begin
            scl_oe_q <= 1'b1;
            bit_q <= 4'h0;
            seq_q <= 2'h0;
            tx_q  <= hs_q ? {touch_i2c_pkg::HS_CODE, 3'h0}
                          : {touch_i2c_pkg::PRESET_CODE, dsel_q, rd_q};
            st_q  <= M_BYTE;
          end
        end
        M_BYTE: begin
          if (ph_q == 2'h0) begin
            if (bit_q != 4'h8) sda_oe_q <= ~is_rx & ~tx_q[7];
            else sda_oe_q <= is_rx & ~last;
          end
          if (ph_q == 2'h1) scl_oe_q <= 1'b0;
          if (ph_q == 2'h2) begin
            if (!scl_s[1]) ph_q <= ph_q;
            else if (bit_q != 4'h8) begin
              rx_q <= is_rx ? {rx_q[14:0], sda_s[1]} : rx_q;
              tx_q <= {tx_q[6:0], 1'b0};
            end else ackin_q <= sda_s[1];
          end
          if (ph_q == 2'h3) begin
            scl_oe_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (hs_q) begin
                hs_q <= 1'b0;
                st_q <= M_START;
              end else if (!is_rx && ackin_q) begin
                nack_q <= 1'b1;
                st_q   <= M_STOP;
              end else if (last) begin
                st_q <= M_STOP;
              end else begin
                seq_q <= seq_q + 2'h1;
                tx_q  <= cmd_q;
              end
            end
          end
        end
        M_STOP: begin
          if (ph_q == 2'h0) sda_oe_q <= 1'b1;
          if (ph_q == 2'h1) scl_oe_q <= 1'b0;
          if (ph_q == 2'h2 && !scl_s[1]) ph_q <= ph_q;
          if (ph_q == 2'h3) begin
            sda_oe_q <= 1'b0;
            busy_q   <= 1'b0;
            if (rd_q && !nack_q) begin
              result_q <= two_q ? rx_q : {rx_q[7:0], 8'h00};
            end
            st_q <= M_IDLE;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  assign bus.scl_m_oe = scl_oe_q;
  assign bus.sda_m_oe = sda_oe_q;

  // ***********************************************************
  // software port
  // ***********************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q   <= 8'h00;
      dsel_q  <= 2'h0;
      rdata_o <= 16'h0000;
    end else begin
      if (wr_i && addr_i == touch_i2c_pkg::REG_CMD) cmd_q <= wdata_i[7:0];
      if (wr_i && addr_i == touch_i2c_pkg::REG_DSEL) dsel_q <= wdata_i[1:0];
      if (!rd_i) rdata_o <= 16'h0000;
      else if (addr_i == touch_i2c_pkg::REG_CMD) rdata_o <= {8'h00, cmd_q};
      else if (addr_i == touch_i2c_pkg::REG_DSEL) rdata_o <= {14'h0, dsel_q};
      else if (addr_i == touch_i2c_pkg::REG_STATUS)
        rdata_o <= {14'h0, nack_q, busy_q};
      else if (addr_i == touch_i2c_pkg::REG_RESULT) rdata_o <= result_q;
      else rdata_o <= 16'h0000;
    end
  end

endmodule

// File: sim/touch_i2c_props.sv
// link checker: address, command acks, high-speed code, stretching
// assumes instantiation beside the interface with its signals as inputs
`timescale 1ns/1ps
module touch_i2c_props (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       scl_s_oe,
  input wire logic       sda_s_oe,
  input wire logic [1:0] device_select_pins_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0]  bits_q;
  logic [7:0]  shift_q;
  logic        hit_q;
  logic [15:0] hold_q;
  logic        addr_ok;
  assign addr_ok = shift_q[7:3] == touch_i2c_pkg::PRESET_CODE &&
                   shift_q[2:1] == device_select_pins_i;
  // ****************
  // helper logic
  // ****************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bits_q <= 6'h00;
    end else if (scl && $fell(sda)) begin
      bits_q <= 6'h00;
    end else if ($rose(scl) && bits_q != 6'h3F) begin
      bits_q <= bits_q + 6'h01;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= 8'h00;
    end else if ($rose(scl)) begin
      shift_q <= {shift_q[6:0], sda};
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_q <= 1'b0;
    end else if ($rose(scl) && bits_q == 6'h08) begin
      hit_q <= !sda && !shift_q[0];
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 16'h0000;
    end else begin
      hold_q <= scl_s_oe ? hold_q + 16'h0001 : 16'h0000;
    end
  end
  // ****************
  // assertions
  // ****************
  a_addr_match_ack: assert property (
    $rose(scl) && bits_q == 6'h08 && addr_ok |-> sda_s_oe)
    else $error("matching address not acknowledged");
  a_addr_miss_nack: assert property (
    $rose(scl) && bits_q == 6'h08 && !addr_ok |-> !sda_s_oe)
    else $error("foreign address acknowledged");
  a_hs_code_nack: assert property (
    $rose(scl) && bits_q == 6'h08 &&
    shift_q[7:3] == touch_i2c_pkg::HS_CODE |-> !sda_s_oe [*8])
    else $error("high-speed code acknowledged");
  a_cmd_byte_ack: assert property (
    $rose(scl) && bits_q == 6'h11 && hit_q |-> sda_s_oe)
    else $error("command byte not acknowledged");
  a_extra_cmd_nack: assert property (
    $rose(scl) && bits_q == 6'h1A && hit_q |-> !sda_s_oe)
    else $error("extra command byte acknowledged");
  a_stretch_low: assert property (
    $rose(scl_s_oe) |-> !scl)
    else $error("stretch begun while clock high");
  a_stretch_bound: assert property (
    scl_s_oe |-> hold_q < 16'h3A98)
    else $error("clock held low too long");
  a_sda_stable_high: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data moved while clock high");
  cover property ($rose(scl) && bits_q == 6'h08 && addr_ok && shift_q[0]);
  cover property ($rose(scl) && bits_q == 6'h11 && hit_q);
  cover property ($rose(scl_s_oe) ##1 scl_s_oe [*8]);
endmodule

// File: sim/touch_adc_i2c_slave_control_tb.sv
// bench: master and slave joined on the link, driven through the port
// assumes package and interface compiled first; converter modelled here
`timescale 1ns/1ps
module touch_adc_i2c_slave_control_tb;
  logic        core_clk_i;
  logic        rst_n_i;
  logic [2:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic [1:0]  pins;
  logic        conv_done_i;
  logic [11:0] result_i;
  logic [3:0]  cfg;
  logic [1:0]  pdf;
  logic        xdrv, ydrv, dref, start, busy, m8, refp, pen, hs;
  logic        mux, acq;
  logic [2:0]  seen;
  logic [15:0] got;
  logic [15:0] st;
  int          bad_count, compares, delay, cnt;
  assign st = {cfg, pdf, m8, refp, dref, xdrv, ydrv, pen, hs, 3'h0};
  touch_i2c_if link ();
  touch_i2c_master u_touch_i2c_master (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .bus(link.master), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  touch_i2c_slave u_touch_i2c_slave (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .bus(link.slave), .device_select_pins_i(pins),
    .conv_done_i(conv_done_i), .result_i(result_i),
    .config_select_field_o(cfg), .mux_en_o(mux), .x_drive_o(xdrv),
    .y_drive_o(ydrv), .diff_ref_o(dref), .acquire_o(acq),
    .conv_start_o(start), .conv_busy_o(busy), .mode_8bit_o(m8),
    .power_down_field_o(pdf), .reference_power_bit_o(refp),
    .pen_touch_interrupt_en_o(pen), .hs_mode_o(hs));
  touch_i2c_props u_touch_i2c_props (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .scl(link.scl), .sda(link.sda),
    .scl_s_oe(link.scl_s_oe), .sda_s_oe(link.sda_s_oe),
    .device_select_pins_i(pins));
  // ****************
  // clock, converter, tasks
  // ****************
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (start) cnt <= delay;
    else if (cnt > 0) cnt <= cnt - 1;
    conv_done_i <= (cnt == 1);
  end
  // sticky record of channel select, acquisition and high-speed mode
  always @(posedge core_clk_i) begin
    if (!rst_n_i) seen <= 3'h0;
    else seen <= seen | {mux, acq, hs};
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  task op(input logic [7:0] c, input logic [1:0] s, input logic [15:0] t);
    int n;
    n = 0;
    wr(touch_i2c_pkg::REG_CMD, {8'h00, c});
    wr(touch_i2c_pkg::REG_DSEL, {14'h0000, s});
    wr(touch_i2c_pkg::REG_CTRL, t);
    rd(touch_i2c_pkg::REG_STATUS);
    while (got[0] !== 1'b0 && n < 40000) begin
      rd(touch_i2c_pkg::REG_STATUS);
      n++;
    end
    if (n >= 40000) bad_count++;
    // slave sees the stop through its synchronisers a few cycles later
    repeat (8) @(posedge core_clk_i);
  endtask
  task cwait;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 20000) bad_count++;
  endtask
  task give_verdict;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    #395000;
    bad_count++;
    give_verdict();
  end
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    pins = 2'h2;
    result_i = 12'h000;
    conv_done_i = 1'b0;
    {delay, cnt, bad_count, compares} = '0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(st, 16'h0010);
    // y position, drivers kept on, read arrives before the result
    delay = 9000;
    result_i = 12'hA5C;
    op(8'hD4, 2'h2, 16'h0001);
    chk(got, 16'h0000);
    chk({14'h0000, mux, acq}, 16'h0000);
    chk(st, 16'hD4A0);
    op(8'h00, 2'h2, 16'h0006);
    rd(touch_i2c_pkg::REG_RESULT);
    chk(got, 16'hA5C0);
    cwait();
    chk(st, 16'hD4A0);
    // eight-bit auxiliary input, reference on, one byte read
    delay = 300;
    result_i = 12'h3B0;
    op(8'h6A, 2'h2, 16'h0001);
    cwait();
    chk(st, 16'h6B10);
    op(8'h00, 2'h2, 16'h0002);
    rd(touch_i2c_pkg::REG_RESULT);
    chk(got, 16'h3B00);
    // foreign device select is refused
    op(8'h00, 2'h1, 16'h0002);
    chk(got, 16'h0002);
    chk(st, 16'h6B10);
    // high-speed prefix, drive-only command sent twice, reference off
    op(8'h80, 2'h2, 16'h000D);
    chk(got, 16'h0002);
    cwait();
    chk(st, 16'h8080);
    chk({13'h0000, seen}, 16'h0007);
    give_verdict();
  end
endmodule
